// [core/sdc_synth_cfg.v]
// Purpose: divider configuration, test select and test mux of a frequency synthesizer
// Assumes: all configuration pins and the oscillator/crystal taps are asynchronous
//   to CLK and are slower than CLK/4 so that each edge is seen after sampling
// Notes: the analog loop is outside; the pre-divider counts crystal tap edges, the loop and output dividers count edges of the oscillator
//   tap (or of the shift clock in bypass) and drive registered outputs
// Behaviour
// R01: synth output is crystal over 8, times loop divider, over output divider.
// R02: host keeps loop divider between 200 and 400 with a 16MHz crystal.
// R03: host loads dividers at power-on in parallel, may retune them serially.
// R04: host steps divider settings in smallest increments to limit transients.
// R05: test pin shows the node chosen by the three-bit test select.
// R06: bypass feeds the shift clock into both dividers; code 110 selects it.
// R07: test select is writable only through the serial port.
// R08: while parallel load strobe is low, test select is forced to 000.
// R09: serial stream order is test select, output divider, then loop divider.
// R10: each serial field is sent most significant bit first.
// R11: output divider ratio is at least 2, so bypass output is at most half shift clock.
// R12: loop counter output on the test pin need not have 50% duty cycle.
// R13: output divider code 00,01,10,11 divides by 2,4,8,16.
// R14: 14-bit shift register advances on each shift clock rise, sampling data.
// R15: parallel port wins; latches follow pins while strobe low, hold at its rise.
// R16: with parallel strobe high, latches follow shift register while load high.
// R17: loop divider field is nine bits so fields fill fourteen positions.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_consts.vh"

module sdc_synth_cfg (
  input wire CLK, // system clock, 250 MHz
  input wire RST_N, // asynchronous reset, active low
  // configuration pins
  input wire SER_CLOCK, // serial shift clock pin
  input wire SER_DATA, // serial data pin
  input wire SER_LOAD, // serial load strobe, latches follow while high
  input wire PAR_LOAD_N, // parallel load strobe, active low
  input wire [8:0] PAR_M, // parallel loop divider value
  input wire [1:0] PAR_N, // parallel output divider code
  // taps from the analog side
  input wire XTAL_IN, // crystal oscillator square tap
  input wire OSC_IN, // oscillator (vco) square tap
  // outputs
  output wire SYNTH_OUT, // synthesized output
  output wire TEST_OUT, // test pin
  output wire [8:0] LOOP_DIV, // active loop divider value to the loop
  // Avalon-MM slave
  input wire [3:0] AVS_ADDRESS, // byte address
  input wire AVS_READ, // read request
  input wire AVS_WRITE, // write request
  input wire [31:0] AVS_WRITEDATA, // write data
  input wire [3:0] AVS_BYTEENABLE, // byte enables
  output wire [31:0] AVS_READDATA, // read data
  output wire AVS_WAITREQUEST // wait request
);

  // synchronised pin levels
  wire [16:0] pins_sync;
  wire s_clk_lvl;
  wire s_dat_lvl;
  wire s_load_lvl;
  wire p_load_n_lvl;
  wire [8:0] p_m_lvl;
  wire [1:0] p_n_lvl;
  wire xtal_lvl;
  wire osc_lvl;

  // edge history of the clock-like pins
  reg s_clk_d_reg;
  reg xtal_d_reg;
  reg osc_d_reg;
  wire s_clk_rise;
  wire xtal_rise;
  wire osc_rise;

  // serial path and configuration latches
  reg [`SDC_SR_W-1:0] sr_reg;
  reg [`SDC_M_W-1:0] cfg_m_reg;
  reg [`SDC_N_W-1:0] cfg_n_reg;
  reg [`SDC_T_W-1:0] cfg_t_reg;

  // divider chain
  reg [`SDC_PREF_DIV_W-1:0] pref_cnt_reg;
  reg [`SDC_M_W-1:0] loop_cnt_reg;
  reg loop_out_reg;
  reg [3:0] out_cnt_reg;
  reg synth_reg;
  reg synth_d_reg;
  reg [1:0] synth4_cnt_reg;
  reg test_reg;
  reg test_next;
  wire bypass;
  wire div_tick;
  wire synth_next;

  // register bus state
  reg ctrl_run_reg;
  reg wait_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  wire bus_req;
  wire bus_go;

  // all pins pass two flip-flops before any logic reads them; the parallel strobe
  // goes in inverted so that the synchroniser's reset value reads as no load
  sdc_sync #(
    .WIDTH(17)
  ) u_pin_sync (
    .CLK(CLK),
    .RST_N(RST_N),
    .D({SER_CLOCK, SER_DATA, SER_LOAD, ~PAR_LOAD_N, PAR_M, PAR_N, XTAL_IN, OSC_IN}),
    .Q(pins_sync)
  );

  assign s_clk_lvl = pins_sync[16];
  assign s_dat_lvl = pins_sync[15];
  assign s_load_lvl = pins_sync[14];
  assign p_load_n_lvl = ~pins_sync[13];
  assign p_m_lvl = pins_sync[12:4];
  assign p_n_lvl = pins_sync[3:2];
  assign xtal_lvl = pins_sync[1];
  assign osc_lvl = pins_sync[0];

  // rising-edge detection on synchronised levels
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_clk_d_reg <= 1'b0;
      xtal_d_reg <= 1'b0;
      osc_d_reg <= 1'b0;
    end else begin
      s_clk_d_reg <= s_clk_lvl;
      xtal_d_reg <= xtal_lvl;
      osc_d_reg <= osc_lvl;
    end
  end

  assign s_clk_rise = s_clk_lvl & ~s_clk_d_reg;
  assign xtal_rise = xtal_lvl & ~xtal_d_reg;
  assign osc_rise = osc_lvl & ~osc_d_reg;

  // serial shift register: first bit sent travels to the top position
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sr_reg <= `SDC_RST_SR;
    end else if (s_clk_rise) begin
      sr_reg <= {sr_reg[`SDC_SR_W-2:0], s_dat_lvl}; // see R14
    end
  end

  // configuration latches: parallel strobe low wins over the serial load
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_m_reg <= `SDC_RST_M;
      cfg_n_reg <= `SDC_RST_N;
      cfg_t_reg <= `SDC_RST_T;
    end else if (!p_load_n_lvl) begin
      cfg_m_reg <= p_m_lvl; // see R15
      cfg_n_reg <= p_n_lvl; // see R15
      cfg_t_reg <= `SDC_T_SRBIT; // see R08 see R07
    end else if (s_load_lvl) begin
      cfg_t_reg <= sr_reg[`SDC_T_HI:`SDC_T_LO]; // see R09 see R10 see R16
      cfg_n_reg <= sr_reg[`SDC_N_HI:`SDC_N_LO]; // see R09 see R10 see R16
      cfg_m_reg <= sr_reg[`SDC_M_HI:`SDC_M_LO]; // see R17 see R16
    end
  end

  // bypass swaps the divider clock source to the shift clock
  assign bypass = (cfg_t_reg == `SDC_T_BYPASS);
  assign div_tick = ctrl_run_reg & (bypass ? s_clk_rise : osc_rise); // see R06

  // crystal over 8 gives the phase reference; the loop forces osc = M x ref
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pref_cnt_reg <= {`SDC_PREF_DIV_W{1'b0}};
    end else if (!ctrl_run_reg) begin
      pref_cnt_reg <= {`SDC_PREF_DIV_W{1'b0}};
    end else if (xtal_rise) begin
      pref_cnt_reg <= pref_cnt_reg + 1'b1; // see R01
    end
  end

  // loop counter: one tick high per M ticks, so duty is not 50%
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      loop_cnt_reg <= {`SDC_M_W{1'b0}};
      loop_out_reg <= 1'b0;
    end else if (!ctrl_run_reg) begin
      loop_cnt_reg <= {`SDC_M_W{1'b0}};
      loop_out_reg <= 1'b0;
    end else if (div_tick) begin
      if (loop_cnt_reg + 9'h001 >= cfg_m_reg) begin
        loop_cnt_reg <= {`SDC_M_W{1'b0}};
        loop_out_reg <= 1'b1; // see R12 see R01
      end else begin
        loop_cnt_reg <= loop_cnt_reg + 9'h001;
        loop_out_reg <= 1'b0;
      end
    end
  end

  // output divider: counter bit n toggles every 2^n ticks, never below 2
  assign synth_next = out_cnt_reg[cfg_n_reg]; // see R13 see R11 see R01

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_cnt_reg <= 4'h0;
      synth_reg <= 1'b0;
      synth_d_reg <= 1'b0;
      synth4_cnt_reg <= 2'h0;
    end else begin
      synth_d_reg <= synth_reg;
      if (!ctrl_run_reg) begin
        out_cnt_reg <= 4'h0;
        synth_reg <= 1'b0;
        synth4_cnt_reg <= 2'h0;
      end else begin
        if (div_tick) begin
          out_cnt_reg <= out_cnt_reg + 4'h1;
        end
        synth_reg <= synth_next;
        if (synth_reg & ~synth_d_reg) begin
          synth4_cnt_reg <= synth4_cnt_reg + 2'h1;
        end
      end
    end
  end

  // test pin multiplexer, registered
  always @* begin
    case (cfg_t_reg)
      `SDC_T_SRBIT: test_next = sr_reg[`SDC_SR_W-1]; // see R05
      `SDC_T_HIGH: test_next = 1'b1; // see R05
      `SDC_T_PREF: test_next = pref_cnt_reg[`SDC_PREF_DIV_W-1]; // see R05
      `SDC_T_LOOP: test_next = loop_out_reg; // see R05
      `SDC_T_SYNTH: test_next = synth_reg; // see R05
      `SDC_T_LOW: test_next = 1'b0; // see R05
      `SDC_T_BYPASS: test_next = loop_out_reg; // see R06
      `SDC_T_SYNTH4: test_next = synth4_cnt_reg[1]; // see R05
      default: test_next = 1'b0;
    endcase
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      test_reg <= 1'b0;
    end else begin
      test_reg <= test_next;
    end
  end

  assign SYNTH_OUT = synth_reg;
  assign TEST_OUT = test_reg;
  assign LOOP_DIV = cfg_m_reg;

  // bus handshake: one wait cycle, then waitrequest low for one edge
  assign bus_req = AVS_READ | AVS_WRITE;
  assign bus_go = bus_req & wait_reg;

  // read data mux, unmapped offsets read zero
  always @* begin
    rdata_next = 32'h00000000;
    case (AVS_ADDRESS)
      `SDC_OFS_CFG: rdata_next[`SDC_SR_W-1:0] = {cfg_t_reg, cfg_n_reg, cfg_m_reg};
      `SDC_OFS_SHIFT: rdata_next[`SDC_SR_W-1:0] = sr_reg;
      `SDC_OFS_CTRL: rdata_next[`SDC_CTRL_RUN] = ctrl_run_reg;
      `SDC_OFS_STATUS: begin
        rdata_next[`SDC_ST_BYPASS] = bypass;
        rdata_next[`SDC_ST_PLOAD] = ~p_load_n_lvl;
        rdata_next[`SDC_ST_SYNTH] = synth_reg;
        rdata_next[`SDC_ST_TEST] = test_reg;
      end
      default: rdata_next = 32'h00000000;
    endcase
  end

  // waitrequest, read data and the control register
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
      ctrl_run_reg <= `SDC_RST_CTRL;
    end else begin
      wait_reg <= ~bus_go;
      if (bus_go & AVS_READ) begin
        rdata_reg <= rdata_next;
      end
      if (~wait_reg & AVS_WRITE & AVS_BYTEENABLE[0] & (AVS_ADDRESS == `SDC_OFS_CTRL)) begin
        ctrl_run_reg <= AVS_WRITEDATA[`SDC_CTRL_RUN];
      end
    end
  end

  assign AVS_READDATA = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;

endmodule // sdc_synth_cfg

`default_nettype wire

// [core/sdc_consts.vh]
// Purpose: shared constants of the synthesizer configuration block
// Assumes: included by bare name from the synthesizer module's design file under core/
// Notes: byte offsets are for the Avalon-MM register window
`ifndef SDC_CONSTS_VH
`define SDC_CONSTS_VH

// serial shift register and its field layout, first bit shifted ends on top
`define SDC_SR_W 14
`define SDC_T_HI 13
`define SDC_T_LO 11
`define SDC_N_HI 10
`define SDC_N_LO 9
`define SDC_M_HI 8
`define SDC_M_LO 0
`define SDC_M_W 9
`define SDC_N_W 2
`define SDC_T_W 3

// test select codes
`define SDC_T_SRBIT 3'h0
`define SDC_T_HIGH 3'h1
`define SDC_T_PREF 3'h2
`define SDC_T_LOOP 3'h3
`define SDC_T_SYNTH 3'h4
`define SDC_T_LOW 3'h5
`define SDC_T_BYPASS 3'h6
`define SDC_T_SYNTH4 3'h7

// fixed reference pre-divider: crystal over 8 feeds the phase detector
`define SDC_PREF_DIV_W 3

// reset values of the configuration latches
`define SDC_RST_M 9'h000
`define SDC_RST_N 2'h0
`define SDC_RST_T 3'h0
`define SDC_RST_SR 14'h0000

// register byte offsets
`define SDC_OFS_CFG 4'h0
`define SDC_OFS_SHIFT 4'h4
`define SDC_OFS_CTRL 4'h8
`define SDC_OFS_STATUS 4'hC

// control register fields and reset value
`define SDC_CTRL_RUN 0
`define SDC_RST_CTRL 1'h1

// status register fields
`define SDC_ST_BYPASS 0
`define SDC_ST_PLOAD 1
`define SDC_ST_SYNTH 2
`define SDC_ST_TEST 3

`endif

// [core/sdc_sync.v]
// Purpose: two-flop synchroniser for a group of asynchronous pins
// Assumes: each bit is an independent level; no bus coherency is implied
// Notes: the first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none

module sdc_sync #(
  parameter WIDTH = 1
) (
  input wire CLK, // system clock
  input wire RST_N, // asynchronous reset, active low
  input wire [WIDTH-1:0] D, // asynchronous input levels
  output wire [WIDTH-1:0] Q // synchronised levels
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // two flip-flops in series; nothing else looks at meta_reg
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= D;
      sync_reg <= meta_reg;
    end
  end

  assign Q = sync_reg;

endmodule // sdc_sync

`default_nettype wire

// [core/sdc_synth_cfg_note.v]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [sim/sdc_asserts.sv]
// Purpose: bus and latch checks of the synthesizer configuration block
// Assumes: pins hold each level at least 3 cycles
// Notes: bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module sdc_asserts (
  input wire logic CLK, // clock
  input wire logic RST_N, // reset, active low
  input wire logic SER_LOAD, // serial load strobe
  input wire logic PAR_LOAD_N, // parallel load, active low
  input wire logic [8:0] PAR_M, // parallel loop divider
  input wire logic [8:0] LOOP_DIV, // active loop divider
  input wire logic [3:0] AVS_ADDRESS, // byte address
  input wire logic AVS_READ, // read request
  input wire logic AVS_WRITE, // write request
  input wire logic [31:0] AVS_READDATA, // read data
  input wire logic AVS_WAITREQUEST // wait request
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [3:0] par_cnt_reg, quiet_cnt_reg;
  logic [8:0] prev_m_reg;
  wire done = AVS_READ && !AVS_WAITREQUEST;
  // count steady parallel-load cycles and quiet latch cycles
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      par_cnt_reg <= 4'h0;
      quiet_cnt_reg <= 4'h0;
      prev_m_reg <= 9'h000;
    end else begin
      prev_m_reg <= PAR_M;
      if (PAR_LOAD_N || PAR_M != prev_m_reg) par_cnt_reg <= 4'h0;
      else if (par_cnt_reg != 4'hF) par_cnt_reg <= par_cnt_reg + 4'h1;
      if (!PAR_LOAD_N || SER_LOAD) quiet_cnt_reg <= 4'h0;
      else if (quiet_cnt_reg != 4'hF) quiet_cnt_reg <= quiet_cnt_reg + 4'h1;
    end
  end
  a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered next cycle");
  a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_wait_idle: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer without request");
  a_rdata_steady: assert property ($changed(AVS_READDATA) |-> done)
    else $error("read data moved outside a read");
  a_unmapped_zero: assert property (done && AVS_ADDRESS[1:0] != 2'h0 |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_select_forced: assert property (done && AVS_ADDRESS == 4'h0 && par_cnt_reg >= 4'h4 |-> AVS_READDATA[13:11] == 3'h0)
    else $error("test select not cleared by parallel load");
  a_loop_follows: assert property (par_cnt_reg >= 4'h6 |-> LOOP_DIV == PAR_M)
    else $error("loop divider not following parallel pins");
  a_loop_holds: assert property (quiet_cnt_reg >= 4'h6 |=> $stable(LOOP_DIV))
    else $error("loop divider moved with both strobes idle");
endmodule // sdc_asserts
bind sdc_synth_cfg sdc_asserts chk_u (.CLK(CLK), .RST_N(RST_N), .SER_LOAD(SER_LOAD),
  .PAR_LOAD_N(PAR_LOAD_N), .PAR_M(PAR_M), .LOOP_DIV(LOOP_DIV), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST));
`default_nettype wire

// [sim/sdc_host_model.sv]
// Purpose: host controller driving the serial and parallel configuration pins
// Assumes: every pin level lasts at least 4 cycles, except the one-cycle inverted data after each tick
// Notes: divider pins idle high as with pull-ups
`timescale 1ns/1ps
`default_nettype none
module sdc_host_model (
  input wire logic CLK, // system clock
  output logic SER_CLOCK, // shift clock
  output logic SER_DATA, // serial data
  output logic SER_LOAD, // serial load strobe
  output logic PAR_LOAD_N, // parallel load, active low
  output logic [8:0] PAR_M, // parallel loop divider
  output logic [1:0] PAR_N // parallel output divider code
);
  // idle pins: shift clock still, strobes inactive
  initial begin
    SER_CLOCK = 1'b0;
    SER_DATA = 1'b0;
    SER_LOAD = 1'b0;
    PAR_LOAD_N = 1'b1;
    PAR_M = 9'h1FF;
    PAR_N = 2'h3;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // one shift clock pulse; data is dropped once its hold has passed
  task automatic tick(input logic d);
    @(posedge CLK);
    SER_DATA <= d;
    hold(4);
    SER_CLOCK <= 1'b1;
    hold(4);
    SER_CLOCK <= 1'b0;
    hold(3);
    SER_DATA <= ~d;
  endtask
  // whole frame, fields in stream order, msb first, then a load pulse
  task automatic send(input logic [13:0] w);
    for (int i = 13; i >= 0; i--) tick(w[i]);
    hold(1);
    SER_LOAD <= 1'b1;
    hold(5);
    SER_LOAD <= 1'b0;
    hold(5);
  endtask
  // parallel load opens; values held until after the strobe rises
  task automatic par_start(input logic [8:0] m, input logic [1:0] n);
    @(posedge CLK);
    PAR_M <= m;
    PAR_N <= n;
    PAR_LOAD_N <= 1'b0;
  endtask
  task automatic par_end;
    @(posedge CLK);
    PAR_LOAD_N <= 1'b1;
    hold(5);
    // released divider pins float back to the pull-up level
    PAR_M <= 9'h1FF;
    PAR_N <= 2'h3;
  endtask
endmodule // sdc_host_model
`default_nettype wire

// [sim/testbench.sv]
// Purpose: self-checking bench of the synthesizer configuration block
// Assumes: oscillator and crystal taps toggle only in the tap scenario
// Notes: bus tasks wait on waitrequest under a bound
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, a, e); end end
module testbench;
  logic CLK, RST_N, SER_CLOCK, SER_DATA, SER_LOAD, PAR_LOAD_N, XTAL_IN, OSC_IN;
  logic AVS_READ, AVS_WRITE, synth_q, test_q;
  logic [8:0] PAR_M;
  logic [1:0] PAR_N;
  logic [3:0] AVS_ADDRESS, AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, q;
  logic [13:0] w;
  logic [2:0] codes [4] = '{3'h1, 3'h5, 3'h0, 3'h1};
  logic [2:0] tcodes [4] = '{3'h2, 3'h3, 3'h4, 3'h7};
  int texp [4] = '{8, 16, 32, 8};
  wire SYNTH_OUT, TEST_OUT, AVS_WAITREQUEST;
  wire [8:0] LOOP_DIV;
  wire [31:0] AVS_READDATA;
  int miscompares, n_checks, rises, trises, cyc;
  sdc_synth_cfg dut_u (.CLK(CLK), .RST_N(RST_N), .SER_CLOCK(SER_CLOCK), .SER_DATA(SER_DATA),
    .SER_LOAD(SER_LOAD), .PAR_LOAD_N(PAR_LOAD_N), .PAR_M(PAR_M), .PAR_N(PAR_N),
    .XTAL_IN(XTAL_IN), .OSC_IN(OSC_IN), .SYNTH_OUT(SYNTH_OUT), .TEST_OUT(TEST_OUT),
    .LOOP_DIV(LOOP_DIV), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
  sdc_host_model host_u (.CLK(CLK), .SER_CLOCK(SER_CLOCK), .SER_DATA(SER_DATA),
    .SER_LOAD(SER_LOAD), .PAR_LOAD_N(PAR_LOAD_N), .PAR_M(PAR_M), .PAR_N(PAR_N));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    AVS_WRITEDATA <= d;
    n = 0;
    do begin @(posedge CLK); n++; end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    q = AVS_READDATA;
    if (n >= 50) miscompares++;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  // count output rises and cut a hang short
  always @(posedge CLK) begin
    synth_q <= SYNTH_OUT;
    test_q <= TEST_OUT;
    if (SYNTH_OUT === 1'b1 && synth_q === 1'b0) rises++;
    if (TEST_OUT === 1'b1 && test_q === 1'b0) trises++;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict;
    end
  end
  initial begin
    RST_N = 1'b0;
    {XTAL_IN, OSC_IN, AVS_READ, AVS_WRITE} = 4'h0;
    AVS_ADDRESS = 4'h0;
    AVS_BYTEENABLE = 4'hF;
    AVS_WRITEDATA = 32'h0;
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLK);
    // control register, read-only and unmapped places
    bus(1'b0, 4'h8, 32'h0); `CHK(q, 32'h1)
    bus(1'b1, 4'h8, 32'h0); bus(1'b0, 4'h8, 32'h0); `CHK(q, 32'h0)
    bus(1'b1, 4'h8, 32'h1);
    bus(1'b1, 4'h0, 32'hFFFF); bus(1'b0, 4'h0, 32'h0); `CHK(q, 32'h0)
    bus(1'b0, 4'h2, 32'h0); `CHK(q, 32'h0)
    // power-on parallel load at the bottom of the locking range
    host_u.par_start(9'h0C8, 2'h1);
    host_u.hold(8);
    bus(1'b0, 4'h0, 32'h0); `CHK(q, 32'h2C8)
    host_u.par_end();
    `CHK(LOOP_DIV, 9'h0C8)
    // serial retune of the loop divider by one step, each constant test level
    foreach (codes[i]) begin
      w = {codes[i], 2'h3, 9'h0C9};
      host_u.send(w);
      bus(1'b0, 4'h4, 32'h0); `CHK(q[13:0], w)
      bus(1'b0, 4'h0, 32'h0); `CHK(q[13:0], w)
      `CHK(TEST_OUT, codes[i] == 3'h1)
    end
    // parallel load overrides and clears the test select
    host_u.par_start(9'h0C9, 2'h3);
    host_u.hold(8);
    bus(1'b0, 4'h0, 32'h0); `CHK(q, 32'h6C9)
    `CHK(TEST_OUT, 1'b0)
    host_u.par_end();
    // bypass: shift clock drives both dividers, every output ratio
    for (int nc = 0; nc < 4; nc++) begin
      host_u.send({3'h6, nc[1:0], 9'h004});
      host_u.hold(8);
      rises = 0;
      trises = 0;
      repeat (32) host_u.tick(1'b0);
      host_u.hold(8);
      `CHK(rises, 16 >> nc)
      `CHK(trises, 8)
    end
    bus(1'b0, 4'hC, 32'h0); `CHK(q[0], 1'b1)
    // taps running for 64 whole periods: remaining test nodes, output divide by 2
    foreach (tcodes[i]) begin
      host_u.send({tcodes[i], 2'h0, 9'h004});
      host_u.hold(8);
      rises = 0;
      trises = 0;
      repeat (128) begin
        repeat (4) @(posedge CLK);
        {XTAL_IN, OSC_IN} <= ~{XTAL_IN, OSC_IN};
      end
      host_u.hold(12);
      `CHK(rises, 32)
      `CHK(trises, texp[i])
    end
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
